// File: ieew_pkg.sv
package ieew_pkg;
  localparam logic [3:0] DEV_CODE = 4'ha;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;
  localparam int PAGE_IDX_W = 7;
  localparam int PAGE_BYTES = 128;
  localparam logic [7:0] PAGE_BYTES_CNT = 8'h80;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int POR_TIME_US = 75;
  // longest time, rounds down
  localparam int POR_CYCLES = (POR_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int BYTE_WR_CYCLES = 256;
  localparam logic [ADDR_W-1:0] RST_ADDR = 16'h0000;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTRL,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_DATA,
    ST_SKIP
  } ieew_state_t;
  typedef enum logic [1:0] {
    C_IDLE,
    C_PUSH,
    C_WAIT
  } ieew_cmt_t;
endpackage : ieew_pkg

// File: ieew_slave.sv
// What this block does
// - slave only; serial clock is input, never driven; straps select one of eight
// - control byte upper nibble must equal the device-type code 1010
// - next three control bits must match the three strap pin levels
// - control byte lsb: one means read, zero means write
// - matching control byte acknowledged by pulling data low on ninth clock
// - after address low acknowledge, pointer loads the sixteen-bit address
// - write cycle starts only on STOP after data; no STOP means no write
// - during write cycle nothing is acknowledged, not even own control byte
// - pointer increments wrap inside the 128-byte page, upper bits kept
// - protected write still acknowledged; after STOP no cycle, ready at once
// - protected write still loads and advances the pointer within the page
// - page write carries up to 128 bytes, ended by STOP
// - over 128 bytes, buffer index wraps and overwrites earliest bytes
// - first buffered byte goes to sent address, rest to following page slots
// - buffered bytes commit one by one, each taking one byte-write time
// - protect pin low allows writes, high at STOP blocks all array writes of that transfer
// - protect pin sampled at STOP; later changes do not affect cycle
// - after supply reset release, hold off bus for at most 75 us
// - data falling with clock high is START, rising is STOP
// - eight bits msb first plus one acknowledge bit, nine clocks per byte
`timescale 1ns/1ps
module ieew_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] cnt;
  wire push = in_valid_in && in_ready_out;
  wire load = (cnt != '0) && (!out_valid_out || out_ready_in);
  assign in_ready_out = (cnt != (AW+1)'(DEPTH));
  // depth must be a power of two so the pointers wrap naturally
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + AW'(1);
      if (load)
        rd_ptr <= rd_ptr + AW'(1);
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(load);
    end
  end
  always_ff @(posedge clk_sys_in)
  begin
    if (push)
      mem[wr_ptr] <= in_data_in;
  end
  // output stage registered so the memory port sees flop outputs
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      out_valid_out <= 1'b0;
      out_data_out <= '0;
    end
    else if (load)
    begin
      out_valid_out <= 1'b1;
      out_data_out <= mem[rd_ptr];
    end
    else if (out_ready_in)
      out_valid_out <= 1'b0;
  end
endmodule : ieew_fifo

module ieew_slave
  import ieew_pkg::*;
#(
  parameter int POR_CNT = POR_CYCLES,
  parameter int BYTE_CNT = BYTE_WR_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic chip_select_strap_lsb_in,
  input wire logic chip_select_strap_mid_in,
  input wire logic chip_select_strap_msb_in,
  input wire logic write_protect_in,
  output logic mem_wr_valid_out,
  input wire logic mem_wr_ready_in,
  output logic [ADDR_W-1:0] mem_wr_addr_out,
  output logic [DATA_W-1:0] mem_wr_data_out,
  output logic busy_out,
  output logic ready_out,
  output logic [ADDR_W-1:0] addr_ptr_out
);
  localparam int POR_W = $clog2(POR_CNT + 1);
  localparam int BW = $clog2(BYTE_CNT + 1);
  // pins are asynchronous: two flops before any logic
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic scl_q;
  logic sda_q;
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin_meta <= 6'h30;
      pin_sync <= 6'h30;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      pin_meta <= {scl_in, sda_in, chip_select_strap_msb_in, chip_select_strap_mid_in,
                   chip_select_strap_lsb_in, write_protect_in};
      pin_sync <= pin_meta;
      scl_q <= pin_sync[5];
      sda_q <= pin_sync[4];
    end
  end
  wire scl_s = pin_sync[5];
  wire sda_s = pin_sync[4];
  wire [2:0] straps = pin_sync[3:1];
  wire wp_s = pin_sync[0];
  wire scl_rise = scl_s && !scl_q;
  wire scl_fall = !scl_s && scl_q;
  wire start_det = scl_s && scl_q && sda_q && !sda_s;
  wire stop_det = scl_s && scl_q && !sda_q && sda_s;

  logic [POR_W-1:0] por_cnt;
  logic por_done;
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      por_cnt <= '0;
      por_done <= 1'b0;
    end
    else if (!por_done)
    begin
      por_cnt <= por_cnt + POR_W'(1);
      por_done <= (por_cnt == POR_W'(POR_CNT - 1));
    end
  end

  ieew_state_t state;
  ieew_state_t next_state;
  ieew_cmt_t cmt_state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic ack_drv;
  logic sda_lvl;
  logic busy;
  logic [ADDR_W-1:0] start_addr;
  logic [ADDR_W-1:0] ptr;
  logic [7:0] byte_cnt;
  logic [PAGE_IDX_W-1:0] buf_idx;
  logic [DATA_W-1:0] page_buf [PAGE_BYTES];
  wire live = por_done && !start_det && !stop_det;
  wire byte_done = live && scl_fall && (bit_cnt == BIT_ACK);
  wire ack_end = live && scl_fall && (bit_cnt == BIT_END);
  wire type_ok = (shift[7:4] == DEV_CODE);
  wire strap_ok = (shift[3:1] == straps);
  wire ctrl_ack = type_ok && strap_ok && !busy;
  wire is_read = shift[0];
  wire give_ack = (state == ST_CTRL) ? ctrl_ack : (state != ST_IDLE && state != ST_SKIP);
  wire data_take = byte_done && (state == ST_DATA);
  wire [ADDR_W-1:0] ptr_inc = {ptr[15:7], ptr[6:0] + 7'h01};
  // a stop after any whole data byte commits unless the protect pin is high, even mid next byte
  wire stop_data = por_done && stop_det && (state == ST_DATA) && (byte_cnt != 8'h00);
  wire commit_go = stop_data && !wp_s;
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE: next_state = ST_IDLE;
      ST_CTRL: next_state = ctrl_ack ? (is_read ? ST_SKIP : ST_ADDR_HI) : ST_SKIP;
      ST_ADDR_HI: next_state = ST_ADDR_LO;
      ST_ADDR_LO: next_state = ST_DATA;
      ST_DATA: next_state = ST_DATA;
      ST_SKIP: next_state = ST_SKIP;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      ack_drv <= 1'b0;
      sda_lvl <= 1'b0;
      start_addr <= RST_ADDR;
      ptr <= RST_ADDR;
      byte_cnt <= 8'h00;
      buf_idx <= '0;
    end
    else if (!por_done)
      state <= ST_IDLE;
    else if (start_det)
    begin
      // restart aborts whatever byte was in flight
      state <= ST_CTRL;
      bit_cnt <= 4'h0;
      ack_drv <= 1'b0;
      byte_cnt <= 8'h00;
      buf_idx <= '0;
    end
    else if (stop_det)
    begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      ack_drv <= 1'b0;
    end
    else
    begin
      if (scl_rise && state != ST_IDLE && bit_cnt != BIT_END)
      begin
        if (bit_cnt != BIT_ACK)
          shift <= {shift[6:0], sda_s};
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (byte_done)
        ack_drv <= give_ack;
      if (byte_done && state == ST_ADDR_HI)
        start_addr[15:8] <= shift;
      if (byte_done && state == ST_ADDR_LO)
        start_addr[7:0] <= shift;
      if (data_take)
      begin
        ptr <= ptr_inc;
        buf_idx <= buf_idx + 7'h01;
        if (byte_cnt != PAGE_BYTES_CNT)
          byte_cnt <= byte_cnt + 8'h01;
      end
      if (ack_end)
      begin
        ack_drv <= 1'b0;
        bit_cnt <= 4'h0;
        state <= next_state;
        if (state == ST_ADDR_LO)
          ptr <= start_addr;
      end
    end
  end
  // buffer is not reset; only slots written this transfer are ever committed
  always_ff @(posedge clk_sys_in)
  begin
    if (data_take)
      page_buf[buf_idx] <= shift;
  end

  logic [ADDR_W-1:0] cmt_base;
  logic [PAGE_IDX_W-1:0] cmt_idx;
  logic [7:0] cmt_left;
  logic [BW-1:0] wait_cnt;
  logic fifo_ready;
  wire fifo_valid = (cmt_state == C_PUSH);
  wire [ADDR_W-1:0] cmt_addr = {cmt_base[15:7], cmt_base[6:0] + cmt_idx};
  wire [ADDR_W+DATA_W-1:0] fifo_word = {cmt_addr, page_buf[cmt_idx]};
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cmt_state <= C_IDLE;
      busy <= 1'b0;
      cmt_base <= RST_ADDR;
      cmt_idx <= '0;
      cmt_left <= 8'h00;
      wait_cnt <= '0;
    end
    else
    begin
      unique case (cmt_state)
        C_IDLE:
          if (commit_go)
          begin
            // protect level taken only here, at the stop edge
            cmt_state <= C_PUSH;
            busy <= 1'b1;
            cmt_base <= start_addr;
            cmt_idx <= '0;
            cmt_left <= byte_cnt;
          end
        C_PUSH:
          if (fifo_ready)
          begin
            cmt_state <= C_WAIT;
            wait_cnt <= BW'(BYTE_CNT - 1);
            cmt_idx <= cmt_idx + 7'h01;
            cmt_left <= cmt_left - 8'h01;
          end
        C_WAIT:
          if (wait_cnt != '0)
            wait_cnt <= wait_cnt - BW'(1);
          else if (cmt_left == 8'h00)
          begin
            cmt_state <= C_IDLE;
            busy <= 1'b0;
          end
          else
            cmt_state <= C_PUSH;
      endcase
    end
  end

  // a stalled memory port stretches the write cycle once the fifo is full, rather than losing bytes
  ieew_fifo #(
    .WIDTH(ADDR_W + DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .in_valid_in(fifo_valid),
    .in_ready_out(fifo_ready),
    .in_data_in(fifo_word),
    .out_valid_out(mem_wr_valid_out),
    .out_ready_in(mem_wr_ready_in),
    .out_data_out({mem_wr_addr_out, mem_wr_data_out})
  );

  assign sda_out = sda_lvl;
  assign sda_oe_out = ack_drv;
  assign busy_out = busy;
  assign ready_out = por_done;
  assign addr_ptr_out = ptr;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  wire ctrl_byte = byte_done && (state == ST_CTRL);
  ctrl_match_ack_a: assert property (ctrl_byte && ctrl_ack |=> sda_oe_out ##1 sda_oe_out)
    else $error("matching control byte not acknowledged");
  type_nack_a: assert property (ctrl_byte && !type_ok |=> !sda_oe_out)
    else $error("wrong device type acknowledged");
  strap_nack_a: assert property (ctrl_byte && !strap_ok |=> !sda_oe_out)
    else $error("strap mismatch acknowledged");
  busy_nack_a: assert property (ctrl_byte && busy |=> !sda_oe_out)
    else $error("acknowledge given while busy");
  page_wrap_a: assert property (data_take |=> ptr == $past(ptr_inc))
    else $error("pointer left its page");
  ptr_load_a: assert property (ack_end && state == ST_ADDR_LO |=> ptr == $past(start_addr))
    else $error("pointer not loaded from address bytes");
  wp_skip_a: assert property (stop_data && wp_s |=> !busy [*2])
    else $error("protected write started a cycle");
  wr_start_a: assert property (commit_go |=> busy && cmt_state == C_PUSH)
    else $error("stop after data did not start write");
  push_busy_a: assert property (fifo_valid |-> busy)
    else $error("array write outside write cycle");
  byte_gap_a: assert property (fifo_valid && fifo_ready |=> !fifo_valid [*2])
    else $error("bytes committed without byte time");
  por_quiet_a: assert property (!por_done |-> !sda_oe_out && state == ST_IDLE)
    else $error("bus active during power-on hold");
  page_commit_c: cover property (commit_go && byte_cnt > 8'h01);
  protect_stop_c: cover property (stop_data && wp_s);
  busy_poll_c: cover property (ctrl_byte && busy && type_ok && strap_ok);
  buf_wrap_c: cover property (data_take && byte_cnt == PAGE_BYTES_CNT);
endmodule : ieew_slave

// File: ieew_master_model.sv
`timescale 1ns/1ps
module ieew_master_model (
  input wire logic clk_sys_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  // sda_out high releases the line to the pull-up
  // clock idles high between frames, never free running
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : tick

  // data falls while clock high
  task automatic start_cond();
    sda_out = 1'b1;
    tick(3);
    scl_out = 1'b1;
    tick(6);
    sda_out = 1'b0;
    tick(6);
    scl_out = 1'b0;
    tick(3);
  endtask : start_cond

  // data rises while clock high; entered with clock low
  task automatic stop_cond();
    sda_out = 1'b0;
    tick(3);
    scl_out = 1'b1;
    tick(6);
    sda_out = 1'b1;
    tick(6);
  endtask : stop_cond

  // msb first, ninth clock samples the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sda_out = b[i];
      tick(3);
      scl_out = 1'b1;
      tick(6);
      scl_out = 1'b0;
      tick(3);
    end
    sda_out = 1'b1;
    tick(3);
    scl_out = 1'b1;
    tick(5);
    ack = (sda_in === 1'b0);
    tick(1);
    scl_out = 1'b0;
    // long low phase lets the slave release and update first
    tick(5);
  endtask : send_byte
endmodule : ieew_master_model

// File: ieew_slave_bench.sv
`timescale 1ns/1ps
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin bad_count++; $display("CHECK FAILED %0t %s", $time, m); end end
module ieew_slave_bench;
  import ieew_pkg::*;
  localparam int POR_N = 20;
  localparam int BYTE_N = 8;
  localparam logic [2:0] STRAPS = 3'h5;
  localparam logic [7:0] CTRL_W = {DEV_CODE, STRAPS, 1'b0};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic scl, sda_m, sda_dev, sda_oe, wp = 1'b0, mem_valid, mem_rdy = 1'b1, busy, ready, ack, ok;
  logic [15:0] mem_addr, ptr;
  logic [7:0] mem_data;
  wire sda_line = sda_m & ~(sda_oe & ~sda_dev);
  logic [15:0] q_addr[$];
  logic [7:0] q_data[$];
  int q_time[$];
  int cyc = 0, bad_count = 0, check_count = 0;

  always #2 clk_sys = ~clk_sys;

  ieew_master_model i_mst (.clk_sys_in(clk_sys), .sda_in(sda_line), .scl_out(scl), .sda_out(sda_m));
  ieew_slave #(.POR_CNT(POR_N), .BYTE_CNT(BYTE_N)) i_dut (.clk_sys_in(clk_sys), .rst_in(rst), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_dev), .sda_oe_out(sda_oe), .chip_select_strap_lsb_in(STRAPS[0]),
    .chip_select_strap_mid_in(STRAPS[1]), .chip_select_strap_msb_in(STRAPS[2]), .write_protect_in(wp),
    .mem_wr_valid_out(mem_valid), .mem_wr_ready_in(mem_rdy), .mem_wr_addr_out(mem_addr),
    .mem_wr_data_out(mem_data), .busy_out(busy), .ready_out(ready), .addr_ptr_out(ptr));

  // array side of the memory port
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (mem_valid === 1'b1 && mem_rdy === 1'b1)
    begin
      q_addr.push_back(mem_addr);
      q_data.push_back(mem_data);
      q_time.push_back(cyc);
    end
  end

  task automatic end_sim();
    if (bad_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task automatic poll(input logic [7:0] c, output logic a);
    i_mst.start_cond();
    i_mst.send_byte(c, a);
    i_mst.stop_cond();
  endtask : poll

  task automatic write_frame(input logic [15:0] a, input int n, input logic [7:0] d0, input logic stop_it,
    output logic all_ok);
    all_ok = 1'b1;
    i_mst.start_cond();
    i_mst.send_byte(CTRL_W, ack);
    all_ok &= ack;
    i_mst.send_byte(a[15:8], ack);
    all_ok &= ack;
    i_mst.send_byte(a[7:0], ack);
    all_ok &= ack;
    `CHK(ptr, a, "pointer load")
    for (int i = 0; i < n; i++)
    begin
      i_mst.send_byte(d0 + i[7:0], ack);
      all_ok &= ack;
    end
    if (stop_it)
      i_mst.stop_cond();
  endtask : write_frame

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy === 1'b1 && n < 4000)
    begin
      @(posedge clk_sys);
      n++;
    end
    #1;
    `CHK(busy, 1'b0, "busy stuck")
  endtask : wait_idle

  task automatic t_select();
    for (int i = 0; i < 8; i++)
    begin
      poll({DEV_CODE, i[2:0], 1'b0}, ack);
      `CHK(ack, (i[2:0] == STRAPS), "strap select")
    end
    poll({4'hb, STRAPS, 1'b0}, ack);
    `CHK(ack, 1'b0, "type code")
    poll({DEV_CODE, STRAPS, 1'b1}, ack);
    `CHK(ack, 1'b1, "read select")
  endtask : t_select

  // protected write: acknowledged, no cycle, pointer still advances
  task automatic t_protect();
    wp = 1'b1;
    write_frame(16'h1234, 2, 8'h11, 1'b1, ok);
    `CHK(ok, 1'b1, "protected acks")
    `CHK(busy, 1'b0, "protected busy")
    `CHK(ptr, 16'h1236, "protected pointer")
    poll(CTRL_W, ack);
    `CHK(ack, 1'b1, "protected ready")
    `CHK(q_addr.size(), 0, "protected beats")
    wp = 1'b0;
  endtask : t_protect

  // repeated start in place of stop throws the data away
  task automatic t_abort();
    write_frame(16'h0200, 1, 8'h77, 1'b0, ok);
    poll(CTRL_W, ack);
    `CHK(busy, 1'b0, "abort busy")
    `CHK(q_addr.size(), 0, "abort beats")
  endtask : t_abort

  // stalled array keeps the cycle open long enough to poll it
  task automatic t_poll_wrap();
    mem_rdy = 1'b0;
    write_frame(16'h07fa, 12, 8'h40, 1'b1, ok);
    wp = 1'b1;
    `CHK(busy, 1'b1, "cycle start")
    `CHK(ptr, 16'h0786, "page wrap pointer")
    poll(CTRL_W, ack);
    `CHK(ack, 1'b0, "busy nack")
    // stalled port: oldest beat stands, buffer full behind it
    `CHK(mem_valid, 1'b1, "stall valid")
    `CHK(mem_addr, 16'h07fa, "stall addr")
    `CHK(mem_data, 8'h40, "stall data")
    `CHK(q_addr.size(), 0, "stall beats")
    mem_rdy = 1'b1;
    wait_idle();
    poll(CTRL_W, ack);
    `CHK(ack, 1'b1, "poll done")
    `CHK(q_addr.size(), 12, "beat count")
    // buffered beats drain back to back once the port frees up
    `CHK(q_time[FIFO_DEPTH] - q_time[0], FIFO_DEPTH, "stall drain")
    for (int k = 0; k < 12; k++)
    begin
      `CHK(q_addr[k], {9'h00f, 7'h7a + k[6:0]}, "beat addr")
      `CHK(q_data[k], 8'h40 + k[7:0], "beat data")
    end
    wp = 1'b0;
  endtask : t_poll_wrap

  // 130 bytes: the first two slots are overwritten
  task automatic t_overflow();
    q_addr.delete();
    q_data.delete();
    q_time.delete();
    write_frame(16'h0100, 130, 8'h00, 1'b1, ok);
    wait_idle();
    `CHK(ptr, 16'h0102, "overflow pointer")
    `CHK(q_addr.size(), 128, "overflow count")
    for (int k = 0; k < 128; k++)
    begin
      `CHK(q_addr[k], 16'h0100 + k[15:0], "overflow addr")
      `CHK(q_data[k], (k < 2) ? 8'h80 + k[7:0] : k[7:0], "overflow data")
      if (k > 0)
        `CHK(q_time[k] - q_time[k-1] >= BYTE_N, 1'b1, "byte spacing")
    end
  endtask : t_overflow

  initial
  begin
    #300000;
    bad_count++;
    end_sim();
  end

  initial
  begin
    repeat (16) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    `CHK(ready, 1'b0, "ready early")
    repeat (POR_N + 2) @(posedge clk_sys);
    #1;
    `CHK(ready, 1'b1, "ready late")
    repeat (6) @(posedge clk_sys);
    #1;
    t_select();
    t_protect();
    t_abort();
    t_poll_wrap();
    t_overflow();
    end_sim();
  end
endmodule : ieew_slave_bench
